// File: hw/bmdec_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module bmdec_decoder (
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire logic                instr_valid,
  input  wire logic [31:0]         instr,
  input  wire logic [31:0]         rs1_data,
  input  wire logic [31:0]         rs2_data,
  input  wire logic [31:0]         rd_data,
  output var  logic                out_valid,
  output var  logic                out_illegal,
  output var  bmdec_pkg::bmdec_op_type out_op,
  output var  logic [31:0]         out_result,
  output var  logic [4:0]          out_width_m1,
  output var  logic [4:0]          out_offset,
  output var  logic [1:0]          out_radix
);
  import bmdec_pkg::*;

  logic [6:0]   opc;
  logic [2:0]   f3;
  logic [1:0]   format_select_bits;
  logic [6:0]   f7;
  logic [4:0]   upper_five_bit_imm;
  logic [4:0]   point_or_offset_imm;
  logic [1:0]   upper_two_bit_imm;
  logic [2:0]   rev_pad;
  bmdec_op_type dec_op;
  logic         dec_bad;
  logic [4:0]   dec_width;
  logic [4:0]   dec_offset;
  logic [1:0]   dec_radix;

  logic         next_valid;
  logic         next_illegal;
  bmdec_op_type next_op;
  logic [31:0]  next_result;
  logic [4:0]   next_width_m1;
  logic [4:0]   next_offset;
  logic [1:0]   next_radix;

  bmdec_op_if op_bus ();

  bmdec_exec u_exec (
    .bus (op_bus)
  );

  assign opc                 = instr[OPC_MSB:OPC_LSB];
  assign f3                  = instr[F3_MSB:F3_LSB];
  assign format_select_bits  = instr[F2_MSB:F2_LSB];
  assign f7                  = instr[F7_MSB:F7_LSB];
  assign upper_five_bit_imm  = instr[UIMM_MSB:UIMM_LSB];
  assign point_or_offset_imm = instr[LIMM_MSB:LIMM_LSB];
  assign upper_two_bit_imm   = instr[RADIX_MSB:RADIX_LSB];
  assign rev_pad             = instr[PAD_MSB:PAD_LSB];

  always_comb begin
    dec_op = OP_NONE;
    dec_bad = 1'b0;
    dec_width = upper_five_bit_imm;
    dec_offset = point_or_offset_imm;
    dec_radix = RADIX_2;
    if (opc == OPC_IMM && f3 == F3_FIELD) begin
      case (format_select_bits)
        F2_GET_S: dec_op = OP_FIELD_GET_SIGNED_IMM;
        F2_GET_U: dec_op = OP_FIELD_GET_UNSIGNED_IMM;
        F2_PUT:   dec_op = OP_FIELD_PUT_IMM;
        default:  dec_bad = 1'b1;
      endcase
    end else if (opc == OPC_IMM && f3 == F3_BITS) begin
      case (format_select_bits)
        F2_CLR: dec_op = OP_BIT_RANGE_CLEAR_IMM;
        F2_SET: dec_op = OP_BIT_RANGE_SET_IMM;
        F2_REV: begin
          if (rev_pad == REV_PAD_ZERO) begin
            dec_op = OP_FFT_INDEX_REVERSE;
            dec_radix = upper_two_bit_imm;
            dec_width = {3'h0, upper_two_bit_imm};
          end else begin
            dec_bad = 1'b1;
          end
        end
        default: dec_bad = 1'b1;
      endcase
    end else if (opc == OPC_REG && f3 == F3_REG) begin
      // field parameters come from the second source register
      dec_width = rs2_data[RS2_W_MSB:RS2_W_LSB];
      dec_offset = rs2_data[RS2_O_MSB:RS2_O_LSB];
      case (f7)
        F7_GET_S: dec_op = OP_FIELD_GET_SIGNED_REG;
        F7_GET_U: dec_op = OP_FIELD_GET_UNSIGNED_REG;
        F7_PUT:   dec_op = OP_FIELD_PUT_REG;
        F7_CLR:   dec_op = OP_BIT_RANGE_CLEAR_REG;
        F7_SET:   dec_op = OP_BIT_RANGE_SET_REG;
        default: begin
          // rest of this opcode belongs to other units; only our funct7 row is claimed
          dec_bad = (f7[F7_GRP_MSB:F7_GRP_LSB] == F7_GROUP);
        end
      endcase
    end
  end

  assign op_bus.op       = dec_op;
  assign op_bus.rs1      = rs1_data;
  assign op_bus.rd       = rd_data;
  assign op_bus.width_m1 = dec_width;
  assign op_bus.offset   = dec_offset;
  assign op_bus.radix    = dec_radix;

  always_comb begin
    next_valid = instr_valid && (dec_op != OP_NONE);
    next_illegal = instr_valid && dec_bad;
    next_op = next_valid ? dec_op : OP_NONE;
    // result cleared when nothing is claimed so stale data never looks live
    next_result = next_valid ? op_bus.result : '0;
    next_width_m1 = next_valid ? dec_width : '0;
    next_offset = next_valid ? dec_offset : '0;
    next_radix = next_valid ? dec_radix : RADIX_2;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_illegal <= 1'b0;
      out_op <= OP_NONE;
      out_result <= '0;
      out_width_m1 <= '0;
      out_offset <= '0;
      out_radix <= RADIX_2;
    end else begin
      out_valid <= next_valid;
      out_illegal <= next_illegal;
      out_op <= next_op;
      out_result <= next_result;
      out_width_m1 <= next_width_m1;
      out_offset <= next_offset;
      out_radix <= next_radix;
    end
  end

  logic imm_field_hit;
  logic imm_bits_hit;
  logic reg_hit;
  logic rev_hit;
  logic [4:0] pts_m1;
  logic [4:0] field_top;
  logic       field_fits;

  assign imm_field_hit = instr_valid && opc == OPC_IMM && f3 == F3_FIELD;
  assign imm_bits_hit  = instr_valid && opc == OPC_IMM && f3 == F3_BITS;
  assign reg_hit       = instr_valid && opc == OPC_REG && f3 == F3_REG;
  assign rev_hit       = imm_bits_hit && format_select_bits == F2_REV && rev_pad == REV_PAD_ZERO;
  assign pts_m1        = point_or_offset_imm - 5'h1;
  assign field_top     = point_or_offset_imm + upper_five_bit_imm;
  assign field_fits    = upper_five_bit_imm <= (LAST_BIT - point_or_offset_imm);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_rev_radix;
    rev_hit |=> out_valid && out_op == OP_FFT_INDEX_REVERSE && out_radix == $past(upper_two_bit_imm);
  endproperty
  a_rev_radix: assert property (p_rev_radix) else $error("reverse radix lost");

  property p_rev_alias;
    rev_hit && (upper_two_bit_imm == RADIX_ALIAS || upper_two_bit_imm == RADIX_2)
      && point_or_offset_imm != 5'h0
      |=> out_result[0] == $past(rs1_data[pts_m1]);
  endproperty
  a_rev_alias: assert property (p_rev_alias) else $error("radix 3 not as radix 2");

  property p_sext_top;
    imm_field_hit && format_select_bits == F2_GET_S && field_fits
      |=> out_result[31] == $past(rs1_data[field_top]);
  endproperty
  a_sext_top: assert property (p_sext_top) else $error("extract sign bit wrong");

  property p_field_ops;
    imm_field_hit && format_select_bits != 2'h3
      |=> out_valid && out_width_m1 == $past(upper_five_bit_imm)
          && out_offset == $past(point_or_offset_imm)
          && (out_op == OP_FIELD_GET_SIGNED_IMM || out_op == OP_FIELD_GET_UNSIGNED_IMM
              || out_op == OP_FIELD_PUT_IMM);
  endproperty
  a_field_ops: assert property (p_field_ops) else $error("field form decode wrong");

  property p_bit_ops;
    imm_bits_hit && format_select_bits == F2_SET
      |=> out_op == OP_BIT_RANGE_SET_IMM && out_result == ($past(rs1_data) | out_result)
          && out_result[$past(point_or_offset_imm)];
  endproperty
  a_bit_ops: assert property (p_bit_ops) else $error("range set decode wrong");

  property p_rev_pad;
    imm_bits_hit && format_select_bits == F2_REV && rev_pad != REV_PAD_ZERO
      |=> out_illegal && !out_valid;
  endproperty
  a_rev_pad: assert property (p_rev_pad) else $error("reverse padding not checked");

  property p_reg_fields;
    reg_hit && (f7 == F7_GET_S || f7 == F7_GET_U || f7 == F7_PUT)
      |=> out_valid && out_width_m1 == $past(rs2_data[RS2_W_MSB:RS2_W_LSB])
          && out_offset == $past(rs2_data[RS2_O_MSB:RS2_O_LSB]);
  endproperty
  a_reg_fields: assert property (p_reg_fields) else $error("reg field params wrong");

  property p_reg_clear;
    reg_hit && f7 == F7_CLR
      |=> out_op == OP_BIT_RANGE_CLEAR_REG && (out_result & ~$past(rs1_data)) == 32'h0
          && !out_result[$past(rs2_data[RS2_O_MSB:RS2_O_LSB])];
  endproperty
  a_reg_clear: assert property (p_reg_clear) else $error("reg clear decode wrong");

  property p_rev_range;
    rev_hit |=> (out_result >> $past(point_or_offset_imm)) == 32'h0;
  endproperty
  a_rev_range: assert property (p_rev_range) else $error("reverse set high bits");

  property p_illegal;
    imm_field_hit && format_select_bits == 2'h3
      |=> (out_illegal && !out_valid) ##1 (!out_illegal || $past(instr_valid));
  endproperty
  a_illegal: assert property (p_illegal) else $error("unmatched not flagged");
endmodule
`default_nettype wire

// File: hw/bmdec_pkg.sv
`default_nettype none
package bmdec_pkg;
  localparam logic [6:0] OPC_IMM      = 7'h5b;
  localparam logic [6:0] OPC_REG      = 7'h2b;
  localparam logic [2:0] F3_FIELD     = 3'h0;
  localparam logic [2:0] F3_BITS      = 3'h1;
  localparam logic [2:0] F3_REG       = 3'h3;
  localparam logic [1:0] F2_GET_S     = 2'h0;
  localparam logic [1:0] F2_GET_U     = 2'h1;
  localparam logic [1:0] F2_PUT       = 2'h2;
  localparam logic [1:0] F2_CLR       = 2'h0;
  localparam logic [1:0] F2_SET       = 2'h1;
  localparam logic [1:0] F2_REV       = 2'h3;
  localparam logic [6:0] F7_GET_S     = 7'h18;
  localparam logic [6:0] F7_GET_U     = 7'h19;
  localparam logic [6:0] F7_PUT       = 7'h1a;
  localparam logic [6:0] F7_CLR       = 7'h1c;
  localparam logic [6:0] F7_SET       = 7'h1d;
  localparam logic [3:0] F7_GROUP     = 4'h3;
  localparam logic [1:0] RADIX_2      = 2'h0;
  localparam logic [1:0] RADIX_4      = 2'h1;
  localparam logic [1:0] RADIX_8      = 2'h2;
  localparam logic [1:0] RADIX_ALIAS  = 2'h3;
  localparam logic [2:0] REV_PAD_ZERO = 3'h0;
  localparam logic [4:0] LAST_BIT     = 5'h1f;
  localparam logic [31:0] ALL_ONES    = 32'hffffffff;
  localparam int OPC_MSB     = 6;
  localparam int OPC_LSB     = 0;
  localparam int F3_MSB      = 14;
  localparam int F3_LSB      = 12;
  localparam int F2_MSB      = 31;
  localparam int F2_LSB      = 30;
  localparam int F7_MSB      = 31;
  localparam int F7_LSB      = 25;
  localparam int F7_GRP_MSB  = 6;
  localparam int F7_GRP_LSB  = 3;
  localparam int UIMM_MSB    = 29;
  localparam int UIMM_LSB    = 25;
  localparam int LIMM_MSB    = 24;
  localparam int LIMM_LSB    = 20;
  localparam int PAD_MSB     = 29;
  localparam int PAD_LSB     = 27;
  localparam int RADIX_MSB   = 26;
  localparam int RADIX_LSB   = 25;
  localparam int RS2_W_MSB   = 9;
  localparam int RS2_W_LSB   = 5;
  localparam int RS2_O_MSB   = 4;
  localparam int RS2_O_LSB   = 0;

  typedef enum logic [3:0] {
    OP_NONE                   = 4'h0,
    OP_FIELD_GET_SIGNED_IMM   = 4'h1,
    OP_FIELD_GET_UNSIGNED_IMM = 4'h2,
    OP_FIELD_PUT_IMM          = 4'h3,
    OP_BIT_RANGE_CLEAR_IMM    = 4'h4,
    OP_BIT_RANGE_SET_IMM      = 4'h5,
    OP_FFT_INDEX_REVERSE      = 4'h6,
    OP_FIELD_GET_SIGNED_REG   = 4'h7,
    OP_FIELD_GET_UNSIGNED_REG = 4'h8,
    OP_FIELD_PUT_REG          = 4'h9,
    OP_BIT_RANGE_CLEAR_REG    = 4'ha,
    OP_BIT_RANGE_SET_REG      = 4'hb
  } bmdec_op_type;
endpackage
`default_nettype wire

// File: hw/bmdec_op_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bmdec_op_if;
  import bmdec_pkg::*;
  bmdec_op_type op;
  logic [31:0]  rs1;
  logic [31:0]  rd;
  logic [4:0]   width_m1;
  logic [4:0]   offset;
  logic [1:0]   radix;
  logic [31:0]  result;
  modport dec (output op, output rs1, output rd, output width_m1, output offset,
               output radix, input result);
  modport exe (input op, input rs1, input rd, input width_m1, input offset,
               input radix, output result);
endinterface
`default_nettype wire

// File: hw/bmdec_exec.sv
`timescale 1ns/1ps
`default_nettype none
module bmdec_exec (
  bmdec_op_if.exe bus
);
  import bmdec_pkg::*;

  // digit sizes are fixed per case so the divisions stay by constants
  function automatic logic [31:0] bmdec_reverse(input logic [31:0] src,
                                                input logic [4:0]  pts,
                                                input logic [1:0]  rad);
    logic [31:0] r;
    int          n;
    int          k;
    int          p;
    int          idx;
    r = '0;
    for (int i = 0; i < 32; i++) begin
      case (rad)
        RADIX_4: begin
          n = int'(pts) / 2;
          k = i / 2;
          p = i % 2;
          idx = (n - 1 - k) * 2 + p;
        end
        RADIX_8: begin
          n = int'(pts) / 3;
          k = i / 3;
          p = i % 3;
          idx = (n - 1 - k) * 3 + p;
        end
        default: begin // radix-2, alias value lands here too
          n = int'(pts);
          k = i;
          p = 0;
          idx = n - 1 - k;
        end
      endcase
      if (k < n) begin
        r[i] = src[idx[4:0]]; // bits beyond the point count stay zero
      end
    end
    return r;
  endfunction

  logic [4:0]  top;
  logic [31:0] topmask;
  logic [31:0] fmask;
  logic [31:0] shifted;

  always_comb begin
    // field clipped at bit 31 when offset plus width overruns the word
    top = (bus.width_m1 > (LAST_BIT - bus.offset)) ? (LAST_BIT - bus.offset) : bus.width_m1;
    topmask = ALL_ONES >> (LAST_BIT - top);
    fmask = topmask << bus.offset;
    shifted = bus.rs1 >> bus.offset;
    case (bus.op)
      OP_FIELD_GET_SIGNED_IMM, OP_FIELD_GET_SIGNED_REG: begin
        // sign taken from the field's own top bit
        bus.result = shifted[top] ? (shifted | ~topmask) : (shifted & topmask);
      end
      OP_FIELD_GET_UNSIGNED_IMM, OP_FIELD_GET_UNSIGNED_REG: begin
        bus.result = shifted & topmask;
      end
      OP_FIELD_PUT_IMM, OP_FIELD_PUT_REG: begin
        bus.result = (bus.rd & ~fmask) | ((bus.rs1 << bus.offset) & fmask);
      end
      OP_BIT_RANGE_CLEAR_IMM, OP_BIT_RANGE_CLEAR_REG: begin
        bus.result = bus.rs1 & ~fmask;
      end
      OP_BIT_RANGE_SET_IMM, OP_BIT_RANGE_SET_REG: begin
        bus.result = bus.rs1 | fmask;
      end
      OP_FFT_INDEX_REVERSE: begin
        bus.result = bmdec_reverse(bus.rs1, bus.offset, bus.radix);
      end
      default: begin
        bus.result = '0;
      end
    endcase
  end
endmodule
`default_nettype wire

// File: dv/bmdec_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
module bmdec_fetch_model (
  input  wire logic        sys_clk,
  output var  logic        instr_valid,
  output var  logic [31:0] instr,
  output var  logic [31:0] rs1_data,
  output var  logic [31:0] rs2_data,
  output var  logic [31:0] rd_data
);
  initial begin
    instr_valid = 1'b0;
    instr = 32'h0;
    rs1_data = 32'h0;
    rs2_data = 32'h0;
    rd_data = 32'h0;
  end
  // calls made back to back put one instruction in every cycle
  task automatic issue(input logic [31:0] ins, input logic [31:0] a,
                       input logic [31:0] b, input logic [31:0] c);
    @(posedge sys_clk);
    #1;
    instr_valid = 1'b1;
    instr = ins;
    rs1_data = a;
    rs2_data = b;
    rd_data = c;
  endtask
  // idle slot scrambles the buses so a stale word cannot pass for a request
  task automatic idle();
    @(posedge sys_clk);
    #1;
    instr_valid = 1'b0;
    instr = ~instr;
    rs1_data = ~rs1_data;
    rs2_data = ~rs2_data;
    rd_data = ~rd_data;
  endtask
endmodule
`default_nettype wire

// File: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bmdec_pkg::*;
  typedef struct {
    logic         ill;
    bmdec_op_type op;
    logic [31:0]  res;
    logic [4:0]   w;
    logic [4:0]   o;
    logic [1:0]   rad;
  } bmdec_exp_type;
  logic sys_clk, rst_n, instr_valid, out_valid, out_illegal;
  logic [31:0] instr, rs1_data, rs2_data, rd_data, out_result;
  logic [4:0] out_width_m1, out_offset;
  logic [1:0] out_radix;
  bmdec_op_type out_op;
  bmdec_exp_type exp_q[$];
  bmdec_exp_type got_e;
  int errors = 0;
  int samples_checked = 0;
  bmdec_decoder i_bmdec_decoder (.sys_clk(sys_clk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr(instr), .rs1_data(rs1_data), .rs2_data(rs2_data), .rd_data(rd_data),
    .out_valid(out_valid), .out_illegal(out_illegal), .out_op(out_op),
    .out_result(out_result), .out_width_m1(out_width_m1), .out_offset(out_offset),
    .out_radix(out_radix));
  bmdec_fetch_model i_bmdec_fetch_model (.sys_clk(sys_clk), .instr_valid(instr_valid),
    .instr(instr), .rs1_data(rs1_data), .rs2_data(rs2_data), .rd_data(rd_data));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] want, input string what);
    samples_checked++;
    if (got !== want) begin
      errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask
  task automatic cmp_op(input bmdec_op_type got, input bmdec_op_type want);
    samples_checked++;
    if (got !== want) begin
      errors++;
      $display("wrong value at %0t: op got %h want %h", $time, got, want);
    end
  endtask
  function automatic bmdec_exp_type predict(input logic [31:0] ins, input logic [31:0] a,
                                            input logic [31:0] b, input logic [31:0] c,
                                            output bit seen);
    bmdec_exp_type e;
    logic [4:0] w, o;
    logic [31:0] m, v;
    int top, d, n;
    e = '{1'b0, OP_NONE, 32'h0, 5'h0, 5'h0, 2'h0};
    seen = 1'b1;
    w = ins[29:25];
    o = ins[24:20];
    if (ins[6:0] == OPC_REG && ins[14:12] == F3_REG && ins[31:28] == F7_GROUP) begin
      w = b[9:5];
      o = b[4:0];
      case (ins[31:25])
        F7_GET_S: e.op = OP_FIELD_GET_SIGNED_REG;
        F7_GET_U: e.op = OP_FIELD_GET_UNSIGNED_REG;
        F7_PUT:   e.op = OP_FIELD_PUT_REG;
        F7_CLR:   e.op = OP_BIT_RANGE_CLEAR_REG;
        F7_SET:   e.op = OP_BIT_RANGE_SET_REG;
        default:  e.op = OP_NONE;
      endcase
    end else if (ins[6:0] == OPC_IMM && ins[14:12] == F3_FIELD) begin
      case (ins[31:30])
        F2_GET_S: e.op = OP_FIELD_GET_SIGNED_IMM;
        F2_GET_U: e.op = OP_FIELD_GET_UNSIGNED_IMM;
        F2_PUT:   e.op = OP_FIELD_PUT_IMM;
        default:  e.op = OP_NONE;
      endcase
    end else if (ins[6:0] == OPC_IMM && ins[14:12] == F3_BITS) begin
      case (ins[31:30])
        F2_CLR:  e.op = OP_BIT_RANGE_CLEAR_IMM;
        F2_SET:  e.op = OP_BIT_RANGE_SET_IMM;
        F2_REV:  e.op = (ins[29:27] == REV_PAD_ZERO) ? OP_FFT_INDEX_REVERSE : OP_NONE;
        default: e.op = OP_NONE;
      endcase
    end else begin
      seen = 1'b0;
    end
    if (e.op == OP_NONE) begin
      e.ill = 1'b1;
      return e;
    end
    e.w = w;
    e.o = o;
    if (e.op == OP_FFT_INDEX_REVERSE) e.rad = ins[26:25];
    m = 32'(((64'h1 << (int'(w) + 1)) - 64'h1) << o);
    v = (a & m) >> o;
    top = (int'(o) + int'(w) > 31) ? 31 : int'(o) + int'(w);
    case (e.op)
      OP_FIELD_GET_UNSIGNED_IMM, OP_FIELD_GET_UNSIGNED_REG: e.res = v;
      OP_FIELD_GET_SIGNED_IMM, OP_FIELD_GET_SIGNED_REG:
        e.res = v[top - int'(o)] ? (v | (ALL_ONES << (top - int'(o)))) : v;
      OP_FIELD_PUT_IMM, OP_FIELD_PUT_REG: e.res = (c & ~m) | ((a << o) & m);
      OP_BIT_RANGE_CLEAR_IMM, OP_BIT_RANGE_CLEAR_REG: e.res = a & ~m;
      OP_BIT_RANGE_SET_IMM, OP_BIT_RANGE_SET_REG: e.res = a | m;
      default: begin
        d = (w[1:0] == RADIX_ALIAS) ? 1 : int'(w[1:0]) + 1;
        n = int'(o) / d;
        for (int i = 0; i < n * d; i++) e.res[i] = a[(n - 1 - i / d) * d + i % d];
      end
    endcase
    return e;
  endfunction
  task automatic send(input logic [31:0] ins);
    logic [31:0] a, b, c;
    bit seen;
    bmdec_exp_type e;
    a = $urandom();
    b = $urandom();
    c = $urandom();
    e = predict(ins, a, b, c, seen);
    if (seen) exp_q.push_back(e);
    i_bmdec_fetch_model.issue(ins, a, b, c);
  endtask
  // monitor: every flagged cycle retires the oldest note
  always @(negedge sys_clk) begin
    if (rst_n === 1'b1 && (out_valid === 1'b1 || out_illegal === 1'b1)) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("wrong value at %0t: output with nothing expected", $time);
      end else begin
        got_e = exp_q.pop_front();
        cmp_val({31'h0, out_illegal}, {31'h0, got_e.ill}, "illegal");
        cmp_val({31'h0, out_valid}, {31'h0, ~got_e.ill}, "valid");
        cmp_op(out_op, got_e.op);
        cmp_val(out_result, got_e.res, "result");
        cmp_val({27'h0, out_width_m1}, {27'h0, got_e.w}, "width");
        cmp_val({27'h0, out_offset}, {27'h0, got_e.o}, "offset");
        cmp_val({30'h0, out_radix}, {30'h0, got_e.rad}, "radix");
      end
    end
  end
  task automatic final_report();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #400000;
    errors++;
    $display("wrong value at %0t: run did not finish", $time);
    final_report();
  end
  initial begin
    logic [31:0] ins;
    int k;
    rst_n = 1'b0;
    void'($urandom(10210));
    repeat (16) @(posedge sys_clk);
    #1;
    cmp_op(out_op, OP_NONE);
    cmp_val({31'h0, out_valid}, 32'h0, "reset valid");
    rst_n = 1'b1;
    for (int rep = 0; rep < 8; rep++) begin
      for (int f = 0; f < 8; f++) begin
        ins = $urandom();
        ins[6:0] = OPC_IMM;
        ins[14:12] = (f < 4) ? F3_FIELD : F3_BITS;
        ins[31:30] = f[1:0];
        if (rep < 4) ins[29:27] = REV_PAD_ZERO;
        send(ins);
      end
      if (rep[0]) i_bmdec_fetch_model.idle();
    end
    $display("test immediate forms done");
    for (int r = 0; r < 4; r++) begin
      for (int p = 0; p < 5; p++) begin
        ins = $urandom();
        ins[6:0] = OPC_IMM;
        ins[14:12] = F3_BITS;
        ins[31:25] = {F2_REV, REV_PAD_ZERO, 2'(r)};
        ins[24:20] = (p == 4) ? 5'h1f : 5'(p * 3);
        send(ins);
      end
    end
    $display("test reverse radix done");
    for (int rep = 0; rep < 4; rep++) begin
      for (int f = 24; f < 34; f++) begin
        ins = $urandom();
        ins[6:0] = OPC_REG;
        ins[14:12] = F3_REG;
        ins[31:25] = (f < 32) ? 7'(f) : 7'h20;
        if (f == 33) ins[14:12] = 3'h2;
        send(ins);
      end
    end
    $display("test register forms done");
    i_bmdec_fetch_model.idle();
    k = 0;
    while (exp_q.size() != 0 && k < 20) begin
      @(posedge sys_clk);
      k++;
    end
    if (exp_q.size() != 0) begin
      errors++;
      $display("wrong value at %0t: answers missing", $time);
    end
    final_report();
  end
endmodule
`default_nettype wire
